// *** shared/ufdeb_regs.vh ***
// Purpose: register indices, field positions, reset values and counts
//          for the serial transceiver with drive enable and baud timer
// Assumes: register index times four is the wishbone byte address
// Notes:   each channel owns eight consecutive indices
`ifndef UFDEB_REGS_VH
`define UFDEB_REGS_VH

// channel control-zero and own-address indices
`define UFDEB_IDX_CTL0_A 12'hF42
`define UFDEB_IDX_ADDR_A 12'hF45
`define UFDEB_IDX_CTL0_B 12'hF4A
`define UFDEB_IDX_ADDR_B 12'hF4D
// distance from channel base to control-zero
`define UFDEB_CTL0_REL 12'h002
`define UFDEB_CHAN_SPAN 12'h008

// offsets inside a channel
`define UFDEB_OFS_DATA 3'h0
`define UFDEB_OFS_STAT 3'h1
`define UFDEB_OFS_CTL0 3'h2
`define UFDEB_OFS_CTL1 3'h3
`define UFDEB_OFS_MASK 3'h4
`define UFDEB_OFS_ADDR 3'h5
`define UFDEB_OFS_BRGH 3'h6
`define UFDEB_OFS_BRGL 3'h7

// control zero fields
`define UFDEB_C0_TEN 7
`define UFDEB_C0_REN 6
`define UFDEB_C0_CLEAR_TO_SEND_GATING 5
`define UFDEB_C0_PEN 4
`define UFDEB_C0_PSEL 3
`define UFDEB_C0_BREAK_SEND_BIT 2
`define UFDEB_C0_STOP2 1
`define UFDEB_C0_LOOP 0

// control one fields
`define UFDEB_C1_MULTINODE_ENABLE 7
`define UFDEB_C1_MULTINODE_MODE_SELECT_HI 6
`define UFDEB_C1_MULTINODE_MODE_SELECT_LO 5
`define UFDEB_C1_TXADR 4
`define UFDEB_C1_DRIVE_ENABLE_POLARITY 3
`define UFDEB_C1_BAUD_TIMER_CONTROL 1

// sticky status fields
`define UFDEB_ST_RDA 0
`define UFDEB_ST_TXE 1
`define UFDEB_ST_NEW_FRAME_FLAG 2
`define UFDEB_ST_PERR 3
`define UFDEB_ST_FERR 4
`define UFDEB_ST_OVR 5
`define UFDEB_ST_TMR 6

// reset values
`define UFDEB_RST_BYTE 8'h00
`define UFDEB_RST_DIV 16'h0000

// baud ticks per bit, half bit, and lead ticks before start bit
`define UFDEB_OVS 5'h10
`define UFDEB_OVS_HALF 4'h7
`define UFDEB_LEAD_TICKS 5'h11

`endif

// *** design/ufdeb_brg.v ***
// Purpose: baud divisor counter, one-cycle tick every divisor clocks
// Assumes: divisor 0 behaves as 1
// Notes:   reloads itself on expiry, so timer ticks repeat
`timescale 1ns/100ps
module ufdeb_brg (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [15:0] div_i,
  output reg tick_o
);

  reg [15:0] cnt_q;

  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      // preload so the first tick comes a full interval after start
      cnt_q <= div_i;
      tick_o <= 1'b0;
    end else if (cnt_q <= 16'h0001) begin
      cnt_q <= div_i;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule

// *** design/ufdeb_uart.v ***
// Purpose: serial transceiver channel with bus drive enable and timer
// Assumes: pins synchronous to clk_i; classic wishbone register slave
// Notes:   baud tick is 16x the bit rate; channel picked by CHAN_B
// Operation
// - mode 11: no address interrupt, newframe first data
// - drive enable covers whole transmitted frame
// - drive enable rises on transmit data write
// - enable leads start bit one to two bits
// - enable drops one clock after stop
// - enable held across back to back characters
// - polarity bit inverts drive enable
// - bit 7 transmit enable, clear-to-send gating
// - bit 6 enables the receiver
// - bit 4 adds parity, multinode overrides
// - bit 3 selects even or odd parity
// - break bit forces line low, aborts
// - address compare gates data available
// - two bytes form sixteen-bit baud divisor
// - timer interrupt every divisor clocks
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ufdeb_regs.vh"
module ufdeb_uart #(
  parameter CHAN_B = 0
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [13:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire rxd_i,
  input wire cts_n_i,
  output reg txd_o,
  output reg de_o,
  output reg irq_o
);

  localparam T_IDLE = 3'h0;
  localparam T_LEAD = 3'h1;
  localparam T_START = 3'h2;
  localparam T_DATA = 3'h3;
  localparam T_NINTH = 3'h4;
  localparam T_STOP = 3'h5;
  localparam T_FIN = 3'h6;

  localparam R_IDLE = 3'h0;
  localparam R_START = 3'h1;
  localparam R_DATA = 3'h2;
  localparam R_NINTH = 3'h3;
  localparam R_STOP = 3'h4;

  localparam [11:0] CTL0_IDX = CHAN_B ? `UFDEB_IDX_CTL0_B :
                                        `UFDEB_IDX_CTL0_A;
  localparam [11:0] BASE_IDX = CTL0_IDX - `UFDEB_CTL0_REL;

  reg [7:0] ctl0_q;
  reg [7:0] ctl1_q;
  reg [7:0] mask_q;
  reg [7:0] addr_q;
  reg [15:0] div_q;
  reg [6:0] sts_q;
  reg [7:0] rxbuf_q;
  reg [7:0] hold_q;
  reg hold_v_q;
  reg rx_adr_q;

  // bus decode
  wire req = cyc_i & stb_i;
  wire [11:0] rel = adr_i[13:2] - BASE_IDX;
  wire hit = (rel < `UFDEB_CHAN_SPAN);
  wire [2:0] ofs = rel[2:0];
  wire wr = req & ack_o & we_i & sel_i[0] & hit;
  wire [7:0] wd = dat_i[7:0];
  wire wr_data = wr && (ofs == `UFDEB_OFS_DATA);

  wire transmit_enable_bit = ctl0_q[`UFDEB_C0_TEN];
  wire ren = ctl0_q[`UFDEB_C0_REN];
  wire parity_enable_bit = ctl0_q[`UFDEB_C0_PEN];
  wire psel = ctl0_q[`UFDEB_C0_PSEL];
  wire break_send_bit = ctl0_q[`UFDEB_C0_BREAK_SEND_BIT];
  wire multinode_enable = ctl1_q[`UFDEB_C1_MULTINODE_ENABLE];
  wire multinode_mode_select_hi = ctl1_q[`UFDEB_C1_MULTINODE_MODE_SELECT_HI];
  wire multinode_mode_select_lo = ctl1_q[`UFDEB_C1_MULTINODE_MODE_SELECT_LO];
  wire timer_on = ctl1_q[`UFDEB_C1_BAUD_TIMER_CONTROL] & ~transmit_enable_bit & ~ren;
  wire ninth_on = multinode_enable | parity_enable_bit;

  wire tick;

  ufdeb_brg u_brg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(transmit_enable_bit | ren | timer_on),
    .div_i(div_q),
    .tick_o(tick)
  );

  // ---------------- transmitter ----------------
  reg [2:0] ts_q;
  reg [2:0] ts_d;
  reg [4:0] tcnt_q;
  reg [2:0] tbit_q;
  reg [7:0] tsh_q;
  reg tninth_q;
  reg tline_q;
  wire de_d;
  wire [4:0] tcnt_nx = tcnt_q + 5'h01;
  wire [4:0] lead_max = `UFDEB_LEAD_TICKS - 5'h01;
  wire bit_end = tick && (tcnt_nx == `UFDEB_OVS);
  // transmitter gated by enable and clear-to-send
  wire tx_ok = transmit_enable_bit & (~ctl0_q[`UFDEB_C0_CLEAR_TO_SEND_GATING] | ~cts_n_i);
  // holding byte counts as taken only once it moves to the shifter,
  // so a write during the lead time replaces the byte still waiting in hold_q
  wire take = (ts_d == T_START) && (ts_q != T_START);

  always @* begin
    ts_d = ts_q;
    case (ts_q)
      T_IDLE: begin
        if (hold_v_q) begin
          ts_d = T_LEAD;
        end
      end
      T_LEAD: begin
        // seventeen ticks: over one bit, under two
        if (tick && tcnt_q >= (`UFDEB_LEAD_TICKS - 5'h01) && tx_ok) begin
          ts_d = T_START;
        end
      end
      T_START: begin
        if (bit_end) begin
          ts_d = T_DATA;
        end
      end
      T_DATA: begin
        if (bit_end && tbit_q == 3'h7) begin
          ts_d = ninth_on ? T_NINTH : T_STOP;
        end
      end
      T_NINTH: begin
        if (bit_end) begin
          ts_d = T_STOP;
        end
      end
      T_STOP: begin
        if (bit_end && (tbit_q == 3'h1 || !ctl0_q[`UFDEB_C0_STOP2])) begin
          ts_d = T_FIN;
        end
      end
      T_FIN: begin
        // next character starts without dropping enable
        ts_d = (hold_v_q && tx_ok) ? T_START : T_IDLE;
      end
      default: begin
        ts_d = T_IDLE;
      end
    endcase
    if (break_send_bit) begin
      ts_d = T_IDLE;
    end
  end

  // enable rises with the data write
  // held one clock past the pin's stop bit
  assign de_d = ((ts_d != T_IDLE) || (ts_q == T_FIN) || wr_data) && !break_send_bit;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ts_q <= T_IDLE;
      tcnt_q <= 5'h00;
      tbit_q <= 3'h0;
      tsh_q <= `UFDEB_RST_BYTE;
      tninth_q <= 1'b0;
      tline_q <= 1'b1;
      de_o <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      ts_q <= ts_d;
      // enable high across start, data, ninth and stop
      de_o <= de_d ^ ctl1_q[`UFDEB_C1_DRIVE_ENABLE_POLARITY];
      // break holds the line at zero
      txd_o <= break_send_bit ? 1'b0 : tline_q;
      if (ts_d != ts_q) begin
        tcnt_q <= 5'h00;
      end else if (tick) begin
        if (ts_q == T_LEAD) begin
          // lead count saturates while clear-to-send holds the start
          tcnt_q <= (tcnt_q == lead_max) ? tcnt_q : tcnt_nx;
        end else begin
          tcnt_q <= bit_end ? 5'h00 : tcnt_nx;
        end
      end
      if (ts_d == T_START && ts_q != T_START) begin
        tsh_q <= hold_q;
        tbit_q <= 3'h0;
        // even or odd parity on send
        tninth_q <= multinode_enable ? ctl1_q[`UFDEB_C1_TXADR] : (^hold_q) ^ psel;
        tline_q <= 1'b0;
      end else if (bit_end) begin
        case (ts_q)
          T_START: begin
            tline_q <= tsh_q[0];
          end
          T_DATA: begin
            tsh_q <= {1'b0, tsh_q[7:1]};
            tbit_q <= (tbit_q == 3'h7) ? 3'h0 : tbit_q + 3'h1;
            tline_q <= (tbit_q == 3'h7) ? (ninth_on ? tninth_q : 1'b1)
                                        : tsh_q[1];
          end
          T_STOP: begin
            tbit_q <= tbit_q + 3'h1;
            tline_q <= 1'b1;
          end
          default: begin
            tline_q <= 1'b1;
          end
        endcase
      end
      // an aborted frame must not leave the line low after break
      if (break_send_bit) begin
        tline_q <= 1'b1;
      end
    end
  end

  // ---------------- receiver ----------------
  reg [2:0] rs_q;
  reg [3:0] rcnt_q;
  reg [2:0] rbit_q;
  reg [7:0] rsh_q;
  reg rninth_q;
  reg rline_q;
  reg matched_q;
  reg first_q;
  wire rx_in = ctl0_q[`UFDEB_C0_LOOP] ? tline_q : rxd_i;
  wire samp = tick && (rcnt_q == `UFDEB_OVS_HALF);
  wire rx_done = samp && (rs_q == R_STOP);
  wire is_adr = multinode_enable & rninth_q;
  wire adr_hit = (rsh_q == addr_q);
  reg deliver;
  reg new_frame_flag;

  always @* begin
    deliver = 1'b0;
    new_frame_flag = 1'b0;
    if (rx_done) begin
      if (!multinode_enable || !multinode_mode_select_hi) begin
        deliver = 1'b1;
        new_frame_flag = is_adr;
      end else if (is_adr) begin
        deliver = adr_hit && !multinode_mode_select_lo;
        new_frame_flag = adr_hit && !multinode_mode_select_lo;
      end else begin
        deliver = matched_q;
        new_frame_flag = matched_q && multinode_mode_select_lo && first_q;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rs_q <= R_IDLE;
      rcnt_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q <= `UFDEB_RST_BYTE;
      rninth_q <= 1'b0;
      rline_q <= 1'b1;
      matched_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      rline_q <= rx_in;
      if (tick) begin
        rcnt_q <= rcnt_q + 4'h1;
      end
      case (rs_q)
        R_IDLE: begin
          if (ren && rline_q && !rx_in) begin
            rs_q <= R_START;
            rcnt_q <= 4'h0;
          end
        end
        R_START: begin
          if (samp) begin
            rs_q <= rline_q ? R_IDLE : R_DATA;
            rbit_q <= 3'h0;
          end
        end
        R_DATA: begin
          if (samp) begin
            rsh_q <= {rline_q, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == 3'h7) begin
              rs_q <= ninth_on ? R_NINTH : R_STOP;
              rninth_q <= 1'b0;
            end
          end
        end
        R_NINTH: begin
          if (samp) begin
            rninth_q <= rline_q;
            rs_q <= R_STOP;
          end
        end
        R_STOP: begin
          if (samp) begin
            rs_q <= R_IDLE;
            if (is_adr) begin
              matched_q <= adr_hit;
              first_q <= 1'b1;
            end else if (deliver) begin
              first_q <= 1'b0;
            end
          end
        end
        default: begin
          rs_q <= R_IDLE;
        end
      endcase
      if (!ren) begin
        rs_q <= R_IDLE;
      end
    end
  end

  // parity checked with the same sense
  wire perr = rx_done && parity_enable_bit && !multinode_enable && ((^rsh_q) ^ psel ^ rninth_q);
  wire ferr = rx_done && !rline_q;

  // ---------------- registers and events ----------------
  reg [6:0] set_ev;
  wire [6:0] clr_ev = (wr && ofs == `UFDEB_OFS_STAT) ? wd[6:0] : 7'h00;

  always @* begin
    set_ev = 7'h00;
    set_ev[`UFDEB_ST_RDA] = deliver;
    set_ev[`UFDEB_ST_TXE] = take;
    set_ev[`UFDEB_ST_NEW_FRAME_FLAG] = new_frame_flag;
    set_ev[`UFDEB_ST_PERR] = perr;
    set_ev[`UFDEB_ST_FERR] = ferr;
    set_ev[`UFDEB_ST_OVR] = deliver && sts_q[`UFDEB_ST_RDA];
    // one event per divisor interval in timer mode
    set_ev[`UFDEB_ST_TMR] = tick && timer_on;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl0_q <= `UFDEB_RST_BYTE;
      ctl1_q <= `UFDEB_RST_BYTE;
      mask_q <= `UFDEB_RST_BYTE;
      addr_q <= `UFDEB_RST_BYTE;
      div_q <= `UFDEB_RST_DIV;
      sts_q <= 7'h00;
      rxbuf_q <= `UFDEB_RST_BYTE;
      rx_adr_q <= 1'b0;
      hold_q <= `UFDEB_RST_BYTE;
      hold_v_q <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      // one wait state, then ack for exactly one cycle
      ack_o <= req & ~ack_o;
      // set beats a clear in the same cycle
      sts_q <= (sts_q & ~clr_ev) | set_ev;
      irq_o <= |(((sts_q & ~clr_ev) | set_ev) & mask_q[6:0]);
      if (deliver) begin
        rxbuf_q <= rsh_q;
        rx_adr_q <= is_adr;
      end
      if (take) begin
        hold_v_q <= 1'b0;
      end
      if (wr) begin
        case (ofs)
          `UFDEB_OFS_DATA: begin
            hold_q <= wd;
            hold_v_q <= 1'b1;
          end
          `UFDEB_OFS_CTL0: ctl0_q <= wd;
          `UFDEB_OFS_CTL1: ctl1_q <= wd;
          `UFDEB_OFS_MASK: mask_q <= wd;
          `UFDEB_OFS_ADDR: addr_q <= wd;
          `UFDEB_OFS_BRGH: div_q[15:8] <= wd;
          `UFDEB_OFS_BRGL: div_q[7:0] <= wd;
          default: begin
          end
        endcase
      end
      if (req && !ack_o) begin
        dat_o <= 32'h00000000;
        if (!we_i && hit) begin
          case (ofs)
            `UFDEB_OFS_DATA: dat_o[7:0] <= rxbuf_q;
            `UFDEB_OFS_STAT: dat_o[10:0] <= {rx_adr_q, hold_v_q,
                                             (ts_q != T_IDLE), 1'b0, sts_q};
            `UFDEB_OFS_CTL0: dat_o[7:0] <= ctl0_q;
            `UFDEB_OFS_CTL1: dat_o[7:0] <= ctl1_q;
            `UFDEB_OFS_MASK: dat_o[7:0] <= mask_q;
            `UFDEB_OFS_ADDR: dat_o[7:0] <= addr_q;
            `UFDEB_OFS_BRGH: dat_o[7:0] <= div_q[15:8];
            `UFDEB_OFS_BRGL: dat_o[7:0] <= div_q[7:0];
            default: dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule

// *** tb/ufdeb_uart_assertions.sv ***
// Purpose: temporal checks on the serial channel pins
// Assumes: register writes seen only as bus cycles at the ports
// Notes:   shadows the few control bits the checks need
`timescale 1ns/100ps
`include "ufdeb_regs.vh"
module ufdeb_uart_assertions #(
  parameter CHAN_B = 0
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [13:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire rxd_i,
  input wire cts_n_i,
  input wire txd_o,
  input wire de_o,
  input wire irq_o
);
  localparam logic [11:0] BA = `UFDEB_IDX_CTL0_A - `UFDEB_CTL0_REL
    + (CHAN_B ? `UFDEB_CHAN_SPAN : 12'h000);
  wire wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  wire [11:0] ix = adr_i[13:2];
  reg ten_q, clear_to_send_gating_q, brk_q, pol_q, pol2_q;
  // polarity lags one more edge, as de_o follows the written bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      ten_q <= 1'b0;
      clear_to_send_gating_q <= 1'b0;
      brk_q <= 1'b0;
      pol_q <= 1'b0;
      pol2_q <= 1'b0;
    end else begin
      pol2_q <= pol_q;
      if (wr && ix == BA + `UFDEB_OFS_CTL0) begin
        ten_q <= dat_i[7];
        clear_to_send_gating_q <= dat_i[5];
        brk_q <= dat_i[2];
      end
      if (wr && ix == BA + `UFDEB_OFS_CTL1)
        pol_q <= dat_i[3];
    end
  end
  wire act = de_o ^ pol2_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_DE_ON_WRITE: assert property (
    wr && ix == BA && !brk_q |-> ##[1:2] act)
    else $error("drive enable missing after data write");
  AST_BRK_LINE: assert property (
    brk_q && $past(brk_q, 2) |-> !txd_o)
    else $error("line not low during break");
  AST_BRK_DE: assert property (
    brk_q && $past(brk_q, 2) |-> !act)
    else $error("drive enable kept during break");
  AST_LOW_IN_DE: assert property (
    !txd_o && !brk_q && !$past(brk_q, 3) |-> act)
    else $error("line low outside drive enable");
  AST_LEAD: assert property (
    $fell(txd_o) && !brk_q |-> $past(act, 16) && $past(act, 8))
    else $error("start bit without enable lead");
  AST_STOP_DROP: assert property (
    $fell(act) && !brk_q && !$past(brk_q)
    |-> $past(txd_o, 2) && $past(txd_o, 12))
    else $error("drive enable fell before stop bit");
  AST_GATE: assert property (
    $fell(txd_o) && !brk_q
    |-> $past(ten_q, 2) && (!$past(clear_to_send_gating_q, 2) || !$past(cts_n_i, 2)))
    else $error("start bit while transmitter gated");
  AST_POL_IDLE: assert property (
    $rose(pol2_q) |-> de_o)
    else $error("inverted drive enable not idling high");
  cover property ($fell(txd_o));
  cover property ($fell(act));
  cover property (brk_q && !txd_o);
endmodule
bind ufdeb_uart ufdeb_uart_assertions #(.CHAN_B(CHAN_B)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i), .cts_n_i(cts_n_i),
  .txd_o(txd_o), .de_o(de_o), .irq_o(irq_o));

// *** tb/ufdeb_xcvr_model.sv ***
// Purpose: remote bus node behind the line transceiver
// Assumes: BC clocks per bit; receive line fails safe high
// Notes:   only frames sent while the driver is on are heard
`timescale 1ns/100ps
module ufdeb_xcvr_model #(
  parameter int BC = 16
) (
  input wire logic clk_i,
  input wire logic de_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [8:0] got;
  logic [8:0] fq[$];
  int nb = 8;
  initial rxd_o = 1'b1;
  always begin
    @(negedge txd_i);
    if (de_i === 1'b1) begin
      repeat (BC / 2) @(posedge clk_i);
      for (int i = 0; i < nb; i++) begin
        repeat (BC) @(posedge clk_i);
        got[i] = txd_i;
      end
      repeat (BC) @(posedge clk_i);
      if (nb == 8)
        got[8] = 1'b0;
      if (txd_i === 1'b1)
        fq.push_back(got);
    end
  end
  task send(input logic [8:0] v, input int n);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (BC) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= v[i];
      repeat (BC) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (2 * BC) @(posedge clk_i);
  endtask
endmodule

// *** tb/uart_framing_driver_enable_brg_tb_top.sv ***
// Purpose: self-checking bench for one serial channel
// Assumes: divisor low byte 1 gives sixteen clocks per bit
// Notes:   controls are only rewritten with the channel idle
`timescale 1ns/100ps
`include "ufdeb_regs.vh"
module uart_framing_driver_enable_brg_tb_top;
  localparam logic [11:0] BA = `UFDEB_IDX_CTL0_A - `UFDEB_CTL0_REL;
  localparam logic [11:0] DT = BA + `UFDEB_OFS_DATA;
  localparam logic [11:0] ST = BA + `UFDEB_OFS_STAT, MK = BA + `UFDEB_OFS_MASK;
  localparam logic [11:0] C0 = BA + `UFDEB_OFS_CTL0, C1 = BA + `UFDEB_OFS_CTL1;
  localparam logic [11:0] AD = BA + `UFDEB_OFS_ADDR, BH = BA + `UFDEB_OFS_BRGH;
  localparam logic [11:0] BL = BA + `UFDEB_OFS_BRGL;
  logic clk_i, rst_i, cyc, stb, we, ack, rxd, cts_n, txd, de, irq, pol, dq;
  logic [13:0] adr;
  logic [31:0] dat, rd;
  logic [7:0] q, a, b, c;
  int bad_count = 0, num_checks = 0, dfall = 0, cn = 0, n, t1;
  wire logic dea = de ^ pol;
  ufdeb_uart #(.CHAN_B(0)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(dat), .dat_o(rd), .ack_o(ack), .rxd_i(rxd), .cts_n_i(cts_n),
    .txd_o(txd), .de_o(de), .irq_o(irq));
  ufdeb_xcvr_model u_xcvr (.clk_i(clk_i), .de_i(dea), .txd_i(txd),
    .rxd_o(rxd));
  always @(posedge clk_i) begin
    cn <= cn + 1;
    dq <= dea;
    if (dq && !dea)
      dfall <= dfall + 1;
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    bad_count++;
    results();
  end
  task results;
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [11:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task rdc(input logic [11:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    chk(q, e);
  endtask
  task waitn(input int m);
    while (u_xcvr.fq.size() < m) begin
      @(posedge clk_i);
    end
    repeat (20) @(posedge clk_i);
  endtask
  task waitirq;
    while (irq !== 1'b1) begin
      @(posedge clk_i);
    end
  endtask
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 14'h0000;
    dat = 32'h00000000;
    cts_n = 1'b0;
    pol = 1'b0;
    void'($urandom(72));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(C0, 8'h00);
    rdc(C1, 8'h00);
    a = $urandom;
    wr(AD, a);
    rdc(AD, a);
    rdc(12'h100, 8'h00);
    wr(BL, 8'h01);
    wr(C0, 8'h80);
    n = u_xcvr.fq.size();
    t1 = dfall;
    b = $urandom;
    wr(DT, b);
    repeat (2) @(posedge clk_i);
    chk(dea, 1'b1);
    repeat (100) @(posedge clk_i);
    c = $urandom;
    wr(DT, c);
    waitn(n + 2);
    chk(u_xcvr.fq[n], b);
    chk(u_xcvr.fq[n + 1], c);
    chk(dfall - t1, 1);
    u_xcvr.nb = 9;
    for (int p = 0; p < 2; p++) begin
      wr(C0, 8'h00);
      wr(C0, p ? 8'h98 : 8'h90);
      n = u_xcvr.fq.size();
      b = $urandom;
      wr(DT, b);
      waitn(n + 1);
      chk(u_xcvr.fq[n], {^b ^ p[0], b});
    end
    u_xcvr.nb = 8;
    wr(C0, 8'h00);
    wr(C1, 8'h08);
    pol <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(de, 1'b1);
    cts_n <= 1'b1;
    wr(C0, 8'hA0);
    n = u_xcvr.fq.size();
    wr(DT, b);
    repeat (300) @(posedge clk_i);
    chk(u_xcvr.fq.size(), n);
    chk(dea, 1'b1);
    cts_n <= 1'b0;
    waitn(n + 1);
    chk(u_xcvr.fq[n], b);
    wr(C0, 8'h00);
    wr(C0, 8'h84);
    repeat (3) @(posedge clk_i);
    chk(txd, 1'b0);
    chk(dea, 1'b0);
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    pol <= 1'b0;
    wr(ST, 8'h7F);
    wr(MK, 8'h01);
    wr(C0, 8'h40);
    u_xcvr.send({1'b0, b}, 8);
    chk(irq, 1'b1);
    rdc(DT, b);
    rdc(ST, 8'h01);
    wr(ST, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(MK, 8'h00);
    u_xcvr.send({1'b0, b}, 8);
    chk(irq, 1'b0);
    wr(ST, 8'h7F);
    wr(C0, 8'h00);
    u_xcvr.send({1'b0, b}, 8);
    rdc(ST, 8'h00);
    wr(C1, 8'hC0);
    wr(C0, 8'h40);
    u_xcvr.send({1'b1, ~a}, 9);
    u_xcvr.send({1'b0, b}, 9);
    rdc(ST, 8'h00);
    u_xcvr.send({1'b1, a}, 9);
    rdc(ST, 8'h05);
    wr(ST, 8'h7F);
    u_xcvr.send({1'b0, b}, 9);
    rdc(DT, b);
    rdc(ST, 8'h01);
    wr(C0, 8'h00);
    wr(C1, 8'hE0);
    wr(C0, 8'h40);
    wr(ST, 8'h7F);
    u_xcvr.send({1'b1, a}, 9);
    rdc(ST, 8'h00);
    u_xcvr.send({1'b0, b}, 9);
    rdc(ST, 8'h05);
    rdc(DT, b);
    wr(C0, 8'h00);
    wr(C1, 8'h00);
    wr(ST, 8'h7F);
    c = $urandom_range(40, 8);
    wr(BH, 8'h01);
    wr(BL, c);
    wr(MK, 8'h40);
    wr(C1, 8'h02);
    waitirq();
    t1 = cn;
    wr(ST, 8'h40);
    repeat (2) @(posedge clk_i);
    waitirq();
    chk(cn - t1, 16'h0100 + c);
    results();
  end
endmodule
